//--- verilog/io_space_map.svh
`ifndef IO_SPACE_MAP_SVH
`define IO_SPACE_MAP_SVH

// Single-cycle range and bit-addressable range
`define IO_FAST_LAST      13'h003F
`define IO_BIT_LAST       13'h001F
// Extended range, load/store only
`define IO_EXT_FIRST      13'h0040
`define IO_EXT_LAST       13'h103F
// Fast port aliases: 4-byte steps from 0x0000
`define IO_PORT_BASE      13'h0000
`define IO_PORT_STEP      13'h0004
`define IO_PORT_COUNT     6
// Scratch bank base, processor register base
`define IO_SCRATCH_BASE   13'h001C
`define IO_CPU_BASE       13'h0030
// Scratch byte offsets within the bank and reset value
`define SCRATCH_OFS_0     2'h0
`define SCRATCH_OFS_3     2'h3
`define SCRATCH_RESET     8'h00
// Example wide registers in the extended range
`define WIDE16_LOW_ADDR   13'h0040
`define WIDE16_HIGH_ADDR  13'h0041
`define WIDE24_BYTE0_ADDR 13'h0044
`define WIDE24_BYTE1_ADDR 13'h0045
`define WIDE24_BYTE2_ADDR 13'h0046
`define WIDE_RESET        8'h00

`endif

//--- verilog/io_space_pkg.sv
package io_space_pkg;

    // Kind of processor access on the register bus
    typedef enum logic [2:0] {
        op_none             = 3'b000,
        op_port_read        = 3'b001,
        op_port_write       = 3'b010,
        memory_read_ops     = 3'b011,
        memory_write_ops    = 3'b100,
        bit_set_op          = 3'b101,
        bit_clear_op        = 3'b110,
        op_bit_test         = 3'b111
    } bus_op_t;

    // One processor request
    typedef struct packed {
        bus_op_t     op;
        logic [12:0] addr;
        logic [7:0]  wdata;
        logic [2:0]  bit_sel;
    } bus_req_t;

    // Answer to the processor
    typedef struct packed {
        logic [7:0] rdata;
        logic       bit_value;
        logic       accepted;
    } bus_rsp_t;

    // Address region decode
    typedef enum logic [2:0] {
        reg_none    = 3'b000,
        reg_port    = 3'b001,
        reg_scratch = 3'b010,
        reg_cpu     = 3'b011,
        reg_wide    = 3'b100
    } region_t;

endpackage : io_space_pkg

//--- verilog/io_space_wide_access_and_scratch.sv
`include "io_space_map.svh"

module io_space_wide_access_and_scratch
    import io_space_pkg::*;
(
    // Clock and reset
    input  wire logic     clk_sys,
    input  wire logic     rst_b,
    // Processor request, one per cycle
    input  wire bus_req_t req,
    // Answer, same cycle as the request
    output bus_rsp_t      rsp,
    // Live values of the example wide registers
    output logic [15:0]   wide16_value,
    output logic [23:0]   wide24_value,
    // Strobes to the fast port aliases and processor registers
    output logic          port_sel,
    output logic          cpu_sel,
    // Read data from the port alias and processor register owners
    input  wire logic [7:0] port_rdata,
    input  wire logic [7:0] cpu_rdata,
    // Peripheral update of the 16-bit register; a bus write to the high byte in the same cycle wins
    input  wire logic       wide16_load,
    input  wire logic [15:0] wide16_load_value
);

    // Decode an address into its region
    function automatic region_t decode_region(input logic [12:0] a);
        if (a < `IO_SCRATCH_BASE)
            decode_region = (a < `IO_PORT_STEP * `IO_PORT_COUNT) ? reg_port : reg_none;
        else if (a <= `IO_BIT_LAST)
            decode_region = reg_scratch;
        else if (a >= `IO_CPU_BASE && a <= `IO_FAST_LAST)
            decode_region = reg_cpu;
        else if (a == `WIDE16_LOW_ADDR || a == `WIDE16_HIGH_ADDR ||
                 (a >= `WIDE24_BYTE0_ADDR && a <= `WIDE24_BYTE2_ADDR))
            decode_region = reg_wide;
        else
            decode_region = reg_none;
    endfunction : decode_region

    // Check that an operation may reach an address
    function automatic logic op_allowed(input bus_op_t o, input logic [12:0] a);
        unique case (o)
            op_none:                         op_allowed = 1'b0;
            op_port_read, op_port_write:     op_allowed = (a <= `IO_FAST_LAST);
            memory_read_ops,
            memory_write_ops:                op_allowed = (a <= `IO_EXT_LAST);
            bit_set_op, bit_clear_op,
            op_bit_test:                     op_allowed = (a <= `IO_BIT_LAST);
        endcase
    endfunction : op_allowed

    // Staging state and read path
    region_t     region;
    logic        allowed;
    logic        is_read;
    logic        is_write;
    logic        is_bit_rmw;
    logic [7:0]  scratch [4];
    logic [7:0]  next_scratch [4];
    logic [7:0]  shadow16;
    logic [7:0]  next_shadow16;
    logic [15:0] next_wide16;
    logic [7:0]  shadow24 [2];
    logic [7:0]  next_shadow24 [2];
    logic [23:0] next_wide24;
    logic [7:0]  read_byte;
    logic [7:0]  bit_mask;

    // Classify the current request
    // Refused requests select nothing and write nothing
    always_comb begin
        region     = decode_region(req.addr);
        allowed    = op_allowed(req.op, req.addr);
        is_read    = allowed && (req.op == op_port_read || req.op == memory_read_ops ||
                                 req.op == op_bit_test);
        is_write   = allowed && (req.op == op_port_write || req.op == memory_write_ops);
        is_bit_rmw = allowed && (req.op == bit_set_op || req.op == bit_clear_op);
        bit_mask   = 8'h01 << req.bit_sel;
        port_sel   = allowed && region == reg_port;
        cpu_sel    = allowed && region == reg_cpu;
    end

    // Scratch bank: plain storage, byte and bit access
    // Bit operations read, modify and write one byte in a single cycle
    generate
        for (genvar i = 0; i < 4; i++) begin : g_scratch
            always_comb begin
                next_scratch[i] = scratch[i];
                if (region == reg_scratch && req.addr[1:0] == 2'(i)) begin
                    if (is_write)
                        next_scratch[i] = req.wdata;
                    else if (is_bit_rmw && req.op == bit_set_op)
                        next_scratch[i] = scratch[i] | bit_mask;
                    else if (is_bit_rmw)
                        next_scratch[i] = scratch[i] & ~bit_mask;
                end
            end
            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b)
                    scratch[i] <= `SCRATCH_RESET;
                else
                    scratch[i] <= next_scratch[i];
            end
        end
    endgenerate

    // Wide register staging through the shadow bytes
    always_comb begin
        next_shadow16    = shadow16;
        next_wide16      = wide16_value;
        next_shadow24[0] = shadow24[0];
        next_shadow24[1] = shadow24[1];
        next_wide24      = wide24_value;
        // A peripheral load loses to a bus write to the high byte below
        if (wide16_load)
            next_wide16 = wide16_load_value;
        if (region == reg_wide && is_write) begin
            unique case (req.addr)
                `WIDE16_LOW_ADDR:   next_shadow16 = req.wdata;
                `WIDE16_HIGH_ADDR:  next_wide16 = {req.wdata, shadow16};
                `WIDE24_BYTE0_ADDR: next_shadow24[0] = req.wdata;
                `WIDE24_BYTE1_ADDR: next_shadow24[1] = req.wdata;
                `WIDE24_BYTE2_ADDR: next_wide24 = {req.wdata, shadow24[1], shadow24[0]};
                default: ;
            endcase
        end else if (region == reg_wide && is_read) begin
            unique case (req.addr)
                `WIDE16_LOW_ADDR:   next_shadow16 = wide16_value[15:8];
                `WIDE24_BYTE0_ADDR: begin
                    next_shadow24[0] = wide24_value[15:8];
                    next_shadow24[1] = wide24_value[23:16];
                end
                default: ;
            endcase
        end
    end

    // Register the staging state
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            shadow16     <= `WIDE_RESET;
            wide16_value <= {2{`WIDE_RESET}};
            shadow24[0]  <= `WIDE_RESET;
            shadow24[1]  <= `WIDE_RESET;
            wide24_value <= {3{`WIDE_RESET}};
        end else begin
            shadow16     <= next_shadow16;
            wide16_value <= next_wide16;
            shadow24[0]  <= next_shadow24[0];
            shadow24[1]  <= next_shadow24[1];
            wide24_value <= next_wide24;
        end
    end

    // Read multiplexer; unassigned or refused reads give zero
    // Wide high bytes come from the shadows, never from live values
    always_comb begin
        read_byte = 8'h00;
        if (is_read) begin
            unique case (region)
                reg_port:    read_byte = port_rdata;
                reg_cpu:     read_byte = cpu_rdata;
                reg_scratch: read_byte = scratch[req.addr[1:0]];
                reg_wide: begin
                    if (req.addr == `WIDE16_LOW_ADDR)
                        read_byte = wide16_value[7:0];
                    else if (req.addr == `WIDE16_HIGH_ADDR)
                        read_byte = shadow16;
                    else if (req.addr == `WIDE24_BYTE0_ADDR)
                        read_byte = wide24_value[7:0];
                    else if (req.addr == `WIDE24_BYTE1_ADDR)
                        read_byte = shadow24[0];
                    else
                        read_byte = shadow24[1];
                end
                default:     read_byte = 8'h00;
            endcase
        end
        rsp.rdata     = read_byte;
        rsp.bit_value = (req.op == op_bit_test) && allowed && read_byte[req.bit_sel];
        rsp.accepted  = allowed;
    end

    // Wide register staging checks; a peripheral load in the same
    // cycle may move the live value, so those cycles are skipped
    a_high_write_commit: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (is_write && req.addr == `WIDE16_HIGH_ADDR && !wide16_load) |=>
        wide16_value == {$past(req.wdata), $past(shadow16)})
        else $error("high write did not commit shadow");
    a_low_write_holds: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (is_write && req.addr == `WIDE16_LOW_ADDR && !wide16_load) |=>
        $stable(wide16_value) && shadow16 == $past(req.wdata))
        else $error("low write changed live register");
    a_low_read_capture: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (is_read && req.addr == `WIDE16_LOW_ADDR) |=>
        shadow16 == $past(wide16_value[15:8]))
        else $error("low read did not capture high byte");
    a_high_read_shadow: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (is_read && req.addr == `WIDE16_HIGH_ADDR) |->
        rsp.rdata == shadow16)
        else $error("high read not from shadow");
    a_wide24_commit: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (is_write && req.addr == `WIDE24_BYTE2_ADDR) |=>
        wide24_value == {$past(req.wdata), $past(shadow24[1]), $past(shadow24[0])})
        else $error("24-bit commit wrong");
    a_wide24_capture: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (is_read && req.addr == `WIDE24_BYTE0_ADDR) |=>
        shadow24[0] == $past(wide24_value[15:8]) && shadow24[1] == $past(wide24_value[23:16]))
        else $error("24-bit low read did not capture");
    a_unmapped_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (is_write && region == reg_none) |=>
        $stable(shadow16) && $stable(shadow24[0]) &&
        $stable(shadow24[1]) && $stable(wide24_value))
        else $error("unmapped write changed state");

    // Scratch bank and bit test checks
    a_scratch_bit_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (is_bit_rmw && req.op == bit_set_op && region == reg_scratch) |=>
        scratch[$past(req.addr[1:0])][$past(req.bit_sel)])
        else $error("bit set lost");
    a_scratch_bit_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (is_bit_rmw && req.op == bit_clear_op && region == reg_scratch) |=>
        !scratch[$past(req.addr[1:0])][$past(req.bit_sel)])
        else $error("bit clear lost");
    a_scratch_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (is_write && region == reg_scratch) |=>
        scratch[$past(req.addr[1:0])] == $past(req.wdata))
        else $error("scratch write lost");
    a_bit_test_value: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.op == op_bit_test && rsp.accepted) |->
        rsp.bit_value == rsp.rdata[req.bit_sel])
        else $error("bit test gave wrong bit");

    // Decode and range checks
    a_ext_no_port_op: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.op == op_port_write && req.addr >= `IO_EXT_FIRST) |->
        !rsp.accepted)
        else $error("port op reached extended range");
    a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (region == reg_none) |->
        rsp.rdata == 8'h00)
        else $error("unmapped read not zero");
    a_bit_op_range: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.op inside {bit_set_op, bit_clear_op, op_bit_test} &&
         req.addr > `IO_BIT_LAST) |-> !rsp.accepted)
        else $error("bit op accepted above bit range");
    a_port_op_range: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.op inside {op_port_read, op_port_write}) |->
        rsp.accepted == (req.addr <= `IO_FAST_LAST))
        else $error("port op range wrong");
    a_mem_beyond_space: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.op == memory_read_ops && req.addr > `IO_EXT_LAST) |->
        !rsp.accepted && rsp.rdata == 8'h00)
        else $error("memory read beyond space accepted");
    a_port_sel_decode: assert property (@(posedge clk_sys) disable iff (!rst_b)
        port_sel |->
        req.addr < `IO_SCRATCH_BASE && req.op != op_none)
        else $error("port select outside alias range");
    a_cpu_sel_decode: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cpu_sel |->
        req.addr >= `IO_CPU_BASE && req.addr <= `IO_FAST_LAST)
        else $error("processor select outside its range");

    // Main scenarios
    c_wide16_write: cover property (@(posedge clk_sys) disable iff (!rst_b)
        (is_write && req.addr == `WIDE16_LOW_ADDR) ##1
        (is_write && req.addr == `WIDE16_HIGH_ADDR));
    c_wide16_read: cover property (@(posedge clk_sys) disable iff (!rst_b)
        (is_read && req.addr == `WIDE16_LOW_ADDR) ##1
        (is_read && req.addr == `WIDE16_HIGH_ADDR));
    c_bit_test_set: cover property (@(posedge clk_sys) disable iff (!rst_b)
        rsp.bit_value);
    c_wide24_commit: cover property (@(posedge clk_sys) disable iff (!rst_b)
        is_write && req.addr == `WIDE24_BYTE2_ADDR);
    c_refused_op: cover property (@(posedge clk_sys) disable iff (!rst_b)
        req.op != op_none && !rsp.accepted);

endmodule : io_space_wide_access_and_scratch

//--- verification/io_space_owner_model.sv
// Stand-in for the port alias and processor register owners
module io_space_owner_model
    import io_space_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // Bus request and selects from the block
    input  wire bus_req_t   req,
    input  wire logic       port_sel,
    input  wire logic       cpu_sel,
    // Read data back to the block
    output logic [7:0]      port_rdata,
    output logic [7:0]      cpu_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [64];
    logic       wr;

    // Store writes that the block routes here
    assign wr = (req.op == op_port_write) || (req.op == memory_write_ops);
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            foreach (mem[i]) mem[i] <= 8'h00;
        end else if ((port_sel || cpu_sel) && wr) begin
            mem[req.addr[5:0]] <= req.wdata;
        end
    end

    // Unselected owners show a changed value, never the real one
    assign port_rdata = port_sel ? mem[req.addr[5:0]] : ~mem[req.addr[5:0]];
    assign cpu_rdata  = cpu_sel ? mem[req.addr[5:0]] : ~mem[req.addr[5:0]];
endmodule : io_space_owner_model

//--- verification/io_space_wide_access_and_scratch_tb.sv
module io_space_wide_access_and_scratch_tb
    import io_space_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        bus_req_t   r;
        logic [9:0] e;
        logic [9:0] m;
    } row_t;
    // Masks over {rdata, bit_value, accepted}
    localparam logic [9:0] m_rd = 10'h3FD;
    localparam logic [9:0] m_ac = 10'h001;
    localparam logic [9:0] m_bt = 10'h003;
    localparam logic [9:0] m_dt = 10'h3FC;
    // Stimulus writes a reserved address only in the refused bit set at 0x0020
    localparam row_t rows [21] = '{
        '{'{op_port_read, 13'h001C, 8'h00, 3'h0}, {8'h00, 2'b01}, m_rd},
        '{'{op_port_write, 13'h001C, 8'hA5, 3'h0}, {8'h00, 2'b01}, m_ac},
        '{'{memory_write_ops, 13'h001F, 8'h3C, 3'h0}, {8'h00, 2'b01}, m_ac},
        '{'{op_port_read, 13'h001C, 8'h00, 3'h0}, {8'hA5, 2'b01}, m_rd},
        '{'{memory_read_ops, 13'h001F, 8'h00, 3'h0}, {8'h3C, 2'b01}, m_rd},
        '{'{bit_set_op, 13'h001D, 8'h00, 3'h3}, {8'h00, 2'b01}, m_ac},
        '{'{op_port_read, 13'h001D, 8'h00, 3'h0}, {8'h08, 2'b01}, m_rd},
        '{'{bit_clear_op, 13'h001C, 8'h00, 3'h0}, {8'h00, 2'b01}, m_ac},
        '{'{op_port_read, 13'h001C, 8'h00, 3'h0}, {8'hA4, 2'b01}, m_rd},
        '{'{op_bit_test, 13'h001C, 8'h00, 3'h2}, {8'h00, 2'b11}, m_bt},
        '{'{op_bit_test, 13'h001C, 8'h00, 3'h0}, {8'h00, 2'b01}, m_bt},
        '{'{op_port_write, 13'h0040, 8'h55, 3'h0}, {8'h00, 2'b00}, m_ac},
        '{'{bit_set_op, 13'h0020, 8'h00, 3'h1}, {8'h00, 2'b00}, m_ac},
        '{'{op_bit_test, 13'h0030, 8'h00, 3'h0}, {8'h00, 2'b00}, m_ac},
        '{'{op_port_write, 13'h0004, 8'h77, 3'h0}, {8'h00, 2'b01}, m_ac},
        '{'{op_port_read, 13'h0004, 8'h00, 3'h0}, {8'h77, 2'b01}, m_rd},
        '{'{op_port_read, 13'h0018, 8'h00, 3'h0}, {8'h00, 2'b01}, m_rd},
        '{'{memory_read_ops, 13'h0018, 8'h00, 3'h0}, {8'h00, 2'b00}, m_dt},
        '{'{memory_read_ops, 13'h1040, 8'h00, 3'h0}, {8'h00, 2'b00}, m_rd},
        '{'{op_port_write, 13'h0030, 8'h5A, 3'h0}, {8'h00, 2'b01}, m_ac},
        '{'{op_port_read, 13'h0030, 8'h00, 3'h0}, {8'h5A, 2'b01}, m_rd}
    };
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    bus_req_t    req = '0;
    bus_rsp_t    rsp;
    logic [15:0] wide16_value;
    logic [23:0] wide24_value;
    logic        port_sel;
    logic        cpu_sel;
    logic [7:0]  port_rdata;
    logic [7:0]  cpu_rdata;
    logic        wide16_load = 1'b0;
    logic [15:0] wide16_load_value = 16'h0000;
    int          errors = 0;
    int          n_compared = 0;
    int          cycles = 0;

    io_space_wide_access_and_scratch u_io_space_wide_access_and_scratch (
        .clk_sys(clk_sys), .rst_b(rst_b), .req(req), .rsp(rsp),
        .wide16_value(wide16_value), .wide24_value(wide24_value),
        .port_sel(port_sel), .cpu_sel(cpu_sel), .port_rdata(port_rdata),
        .cpu_rdata(cpu_rdata), .wide16_load(wide16_load),
        .wide16_load_value(wide16_load_value));
    io_space_owner_model u_io_space_owner_model (
        .clk_sys(clk_sys), .rst_b(rst_b), .req(req), .port_sel(port_sel),
        .cpu_sel(cpu_sel), .port_rdata(port_rdata), .cpu_rdata(cpu_rdata));

    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    // One request for one cycle, answer checked before the taking edge
    task automatic op(input bus_op_t o, input logic [12:0] a, input logic [7:0] d,
                      input logic [9:0] e, input logic [9:0] m);
        @(negedge clk_sys);
        req = '{o, a, d, 3'h0};
        #1;
        chk({14'h0, rsp & m}, {14'h0, e & m}, "answer");
    endtask : op

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict

    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            give_verdict();
        end
    end

    initial begin
        repeat (2) @(negedge clk_sys);
        rst_b = 1'b1;
        foreach (rows[i]) begin
            @(negedge clk_sys);
            req = rows[i].r;
            #1;
            chk({14'h0, rsp & rows[i].m}, {14'h0, rows[i].e & rows[i].m}, "row");
        end
        // Owner selects follow the address decode
        op(op_port_read, 13'h0008, 8'h00, {8'h00, 2'b01}, m_rd);
        chk({22'h0, port_sel, cpu_sel}, 24'h00_0002, "port select");
        op(op_port_read, 13'h0030, 8'h00, {8'h5A, 2'b01}, m_rd);
        chk({22'h0, port_sel, cpu_sel}, 24'h00_0001, "cpu select");
        op(op_port_read, 13'h001C, 8'h00, {8'hA4, 2'b01}, m_rd);
        chk({22'h0, port_sel, cpu_sel}, 24'h00_0000, "no select");
        // Staged 16-bit write, low byte first
        op(memory_write_ops, 13'h0040, 8'h34, 10'h001, 10'h001);
        op(op_none, 13'h0000, 8'h00, 10'h000, 10'h001);
        chk({8'h00, wide16_value}, 24'h00_0000, "low write");
        op(memory_write_ops, 13'h0041, 8'h12, 10'h001, 10'h001);
        op(op_none, 13'h0000, 8'h00, 10'h000, 10'h001);
        chk({8'h00, wide16_value}, 24'h00_1234, "high write");
        // Staged 16-bit read, live value moves between the two halves
        @(negedge clk_sys);
        wide16_load = 1'b1;
        wide16_load_value = 16'hBEEF;
        @(negedge clk_sys);
        wide16_load = 1'b0;
        #1;
        // No other wide access between the halves
        op(memory_read_ops, 13'h0040, 8'h00, {8'hEF, 2'b01}, m_rd);
        @(negedge clk_sys);
        wide16_load = 1'b1;
        wide16_load_value = 16'h0000;
        req = '0;
        op(memory_read_ops, 13'h0041, 8'h00, {8'hBE, 2'b01}, m_rd);
        wide16_load = 1'b0;
        // 24-bit staged write and read
        op(memory_write_ops, 13'h0044, 8'h11, 10'h001, 10'h001);
        op(memory_write_ops, 13'h0045, 8'h22, 10'h001, 10'h001);
        op(op_none, 13'h0000, 8'h00, 10'h000, 10'h001);
        chk(wide24_value, 24'h00_0000, "24 staged");
        op(memory_write_ops, 13'h0046, 8'h33, 10'h001, 10'h001);
        op(memory_read_ops, 13'h0044, 8'h00, {8'h11, 2'b01}, m_rd);
        chk(wide24_value, 24'h33_2211, "24 commit");
        op(memory_read_ops, 13'h0045, 8'h00, {8'h22, 2'b01}, m_rd);
        op(memory_read_ops, 13'h0046, 8'h00, {8'h33, 2'b01}, m_rd);
        // Second reset clears scratch and wide registers
        @(negedge clk_sys);
        req = '0;
        rst_b = 1'b0;
        @(negedge clk_sys);
        rst_b = 1'b1;
        chk(wide24_value, 24'h00_0000, "reset wide");
        op(op_port_read, 13'h001C, 8'h00, {8'h00, 2'b01}, m_rd);
        op(op_port_read, 13'h001F, 8'h00, {8'h00, 2'b01}, m_rd);
        give_verdict();
    end
endmodule : io_space_wide_access_and_scratch_tb
